//--- logic/tcp_core_ports.sv
// Contract
// - One 64-bit instruction local port
// - Two 32-bit data ports by address bit 2
// - Reads and writes may repeat harmlessly
// - Ignore error and retry when speculative
// - Hold read sampling while wait asserted
// - Memory error raises fault for access
// - Misaligned Device access gives alignment fault
// - Faulting read data discarded, no update
// - Faulting write never reaches the port
// - No attributes or permissions on port
// - Local memory always normal non-cacheable
// - Size power of two 4KB-16MB or zero
// - Each data port holds half size
// - Beyond size goes to main bus
// - Priority load/store, prefetch, then slave
// - Lower requesters stall while port busy
// - Each request tags its source
// - Reissue access when retry requested
// - Retry only when side enable set
// - Ports independent, own address and data
// - Prefetch reads only; others read/write
// - Fixed base address per port
//
// Purpose: Core end of the instruction and two data local memory ports.
// Assumes: Requesters hold a request until done pulses for them.
// Notes:   Sizes and bases are integration parameters, not software state.
module tcp_core_ports
  import tcp_pkg::*;
#(
  parameter int          ILOG2 = TCP_ILOG2_SIZE,
  parameter int          DLOG2 = TCP_DLOG2_SIZE,
  parameter logic [31:0] IBASE = TCP_IBASE,
  parameter logic [31:0] DBASE = TCP_DBASE
) (
  // Clock and reset
  input  wire logic         clk,
  input  wire logic         rst,
  // Retry enables per side
  input  wire logic         instr_retry_enable,
  input  wire logic         data_retry_enable,
  // Load/store unit request
  input  wire logic         lsu_req,
  input  wire logic         lsu_wr,
  input  wire logic [31:0]  lsu_addr,
  input  wire logic [3:0]   lsu_strb,
  input  wire logic [31:0]  lsu_wdata,
  input  wire logic         lsu_spec,
  input  wire logic         lsu_mpu_fault,
  input  wire logic         lsu_dev_type,
  // Prefetch unit request, read only
  input  wire logic         pfu_req,
  input  wire logic [31:0]  pfu_addr,
  input  wire logic         pfu_spec,
  input  wire logic         pfu_mpu_fault,
  // System slave port request
  input  wire logic         sys_req,
  input  wire logic         sys_wr,
  input  wire logic [31:0]  sys_addr,
  input  wire logic [3:0]   sys_strb,
  input  wire logic [31:0]  sys_wdata,
  // Completion to requesters
  output tcp_src_t          done_src,
  output logic [63:0]       done_rdata,
  output logic              done_fault,
  output logic              done_load_ok,
  output logic              usage_fault_a,
  output tcp_src_t          stall_src,
  // Forward to main bus master port
  output logic              main_bus_master_port_req,
  output logic [31:0]       main_bus_master_port_addr,
  output tcp_src_t          main_bus_master_port_src,
  // Local ports
  tcp_link_if.core          instruction_local_ram,
  tcp_link_if.core          data_port_even,
  tcp_link_if.core          data_port_odd
);
  import tcp_pkg::*;

  // Size check on parameters
  localparam int DHALF = (DLOG2 == 0) ? 0 : DLOG2 - 1;
  localparam logic SIZE_OK = (ILOG2 == 0 || (ILOG2 >= TCP_LOG2_MIN && ILOG2 <= TCP_LOG2_MAX))
    && (DLOG2 == 0 || (DLOG2 >= TCP_LOG2_MIN && DLOG2 <= TCP_LOG2_MAX));

  ////////////////////////////////////////////////////////////////////////////
  // Region decode, fixed bases, beyond size goes out
  function automatic logic hit(input logic [31:0] a, input logic [31:0] base, input int lg);
    logic [31:0] span;
    span = (lg == 0) ? 32'h0000_0000 : (32'h0000_0001 << lg);
    hit  = SIZE_OK && (lg != 0) && (a >= base) && ((a - base) < span);
  endfunction : hit

  // Local hit indices: 0 instr, 1 even, 2 odd
  function automatic logic [2:0] decode(input logic [31:0] a);
    decode = 3'h0;
    if (hit(a, IBASE, ILOG2)) begin
      decode[0] = 1'b1;
    end else if (hit(a, DBASE, DLOG2)) begin
      decode[a[TCP_BANK_BIT] ? 2 : 1] = 1'b1;
    end
  endfunction : decode

  logic [2:0] lsu_hit, pfu_hit, sys_hit;
  logic       lsu_algn;
  always_comb begin
    lsu_hit  = decode(lsu_addr);
    pfu_hit  = decode(pfu_addr);
    sys_hit  = decode(sys_addr);
    // Partial strobe pattern not naturally aligned
    lsu_algn = lsu_dev_type && !(lsu_strb == 4'hF || lsu_strb == 4'h3 || lsu_strb == 4'hC
      || lsu_strb == 4'h1 || lsu_strb == 4'h2 || lsu_strb == 4'h4 || lsu_strb == 4'h8);
  end

  ////////////////////////////////////////////////////////////////////////////
  // Per-port arbitration and sequencing; ports independent
  tcp_state_t  st_reg   [3];
  tcp_src_t    own_reg  [3];
  logic        spec_reg [3];
  logic        flt_reg  [3];
  logic        wr_reg   [3];
  logic [31:0] a_reg    [3];
  logic [3:0]  s_reg    [3];
  logic [31:0] wd_reg   [3];
  logic        req_reg  [3];
  logic [63:0] rd_w     [3];
  logic        wt_w     [3];
  logic        er_w     [3];
  logic        rt_w     [3];
  logic        ren      [3];
  tcp_src_t    win      [3];

  // Gather answers; attributes never leave the core
  always_comb begin
    rd_w[0] = instruction_local_ram.rdata;
    rd_w[1] = {32'h0000_0000, data_port_even.rdata};
    rd_w[2] = {32'h0000_0000, data_port_odd.rdata};
    wt_w[0] = instruction_local_ram.wait_st;
    wt_w[1] = data_port_even.wait_st;
    wt_w[2] = data_port_odd.wait_st;
    er_w[0] = instruction_local_ram.err;
    er_w[1] = data_port_even.err;
    er_w[2] = data_port_odd.err;
    rt_w[0] = instruction_local_ram.retry;
    rt_w[1] = data_port_even.retry;
    rt_w[2] = data_port_odd.retry;
    ren[0]  = instr_retry_enable;
    ren[1]  = data_retry_enable;
    ren[2]  = data_retry_enable;
    // Fixed priority load/store, prefetch, slave
    for (int p = 0; p < 3; p++) begin
      if (lsu_req && lsu_hit[p]) begin
        win[p] = TCP_SRC_LSU;
      end else if (pfu_req && pfu_hit[p]) begin
        win[p] = TCP_SRC_FETCH;
      end else if (sys_req && sys_hit[p]) begin
        win[p] = TCP_SRC_SLAVE;
      end else begin
        win[p] = TCP_SRC_NONE;
      end
    end
  end

  logic [2:0] fin;
  for (genvar p = 0; p < 3; p++) begin : g_port
    logic ans;
    // Answer in the first non-waited cycle after the request pulse
    assign ans = (st_reg[p] == TCP_ST_RESP) && !req_reg[p] && !wt_w[p];
    assign fin[p] = ans && !(ren[p] && rt_w[p] && !spec_reg[p]);
    // One-cycle request, wait before sampling, retry reissue
    always_ff @(posedge clk) begin
      if (rst) begin
        st_reg[p]  <= TCP_ST_IDLE;
        own_reg[p] <= TCP_SRC_NONE;
        req_reg[p] <= TCP_RST_BIT;
        spec_reg[p] <= 1'b0;
        flt_reg[p] <= 1'b0;
        wr_reg[p]  <= 1'b0;
        a_reg[p]   <= 32'h0000_0000;
        s_reg[p]   <= 4'h0;
        wd_reg[p]  <= 32'h0000_0000;
      end else begin
        req_reg[p] <= 1'b0;
        case (st_reg[p])
          TCP_ST_IDLE: begin
            if (win[p] != TCP_SRC_NONE) begin
              own_reg[p] <= win[p];
              case (win[p])
                TCP_SRC_LSU: begin
                  wr_reg[p]   <= lsu_wr;
                  a_reg[p]    <= lsu_addr;
                  s_reg[p]    <= lsu_strb;
                  wd_reg[p]   <= lsu_wdata;
                  spec_reg[p] <= lsu_spec;
                  flt_reg[p]  <= lsu_mpu_fault || lsu_algn;
                  // Faulting write kept off the port
                  req_reg[p]  <= !(lsu_wr && (lsu_mpu_fault || lsu_algn));
                end
                TCP_SRC_FETCH: begin
                  wr_reg[p]   <= 1'b0;
                  a_reg[p]    <= pfu_addr;
                  s_reg[p]    <= 4'hF;
                  spec_reg[p] <= pfu_spec;
                  flt_reg[p]  <= pfu_mpu_fault;
                  req_reg[p]  <= 1'b1;
                end
                default: begin
                  wr_reg[p]   <= sys_wr;
                  a_reg[p]    <= sys_addr;
                  s_reg[p]    <= sys_strb;
                  wd_reg[p]   <= sys_wdata;
                  spec_reg[p] <= 1'b0;
                  flt_reg[p]  <= 1'b0;
                  req_reg[p]  <= 1'b1;
                end
              endcase
              st_reg[p] <= TCP_ST_RESP;
            end
          end
          TCP_ST_RESP: begin
            if (!req_reg[p] && wr_reg[p] && flt_reg[p]) begin
              st_reg[p] <= TCP_ST_DONE;
            end else if (ans && !fin[p]) begin
              req_reg[p] <= 1'b1;
            end else if (fin[p]) begin
              st_reg[p] <= TCP_ST_DONE;
            end
          end
          TCP_ST_DONE: st_reg[p] <= TCP_ST_IDLE;
          default:     st_reg[p] <= TCP_ST_IDLE;
        endcase
      end
    end
  end

  // Drive ports; source tag on each request
  always_comb begin
    instruction_local_ram.req   = req_reg[0];
    instruction_local_ram.wr    = wr_reg[0];
    instruction_local_ram.addr  = a_reg[0];
    instruction_local_ram.strb  = a_reg[0][2] ? {s_reg[0], 4'h0} : {4'h0, s_reg[0]};
    instruction_local_ram.wdata = {wd_reg[0], wd_reg[0]};
    instruction_local_ram.src   = own_reg[0];
    data_port_even.req   = req_reg[1];
    data_port_even.wr    = wr_reg[1];
    data_port_even.addr  = a_reg[1];
    data_port_even.strb  = s_reg[1];
    data_port_even.wdata = wd_reg[1];
    data_port_even.src   = own_reg[1];
    data_port_odd.req    = req_reg[2];
    data_port_odd.wr     = wr_reg[2];
    data_port_odd.addr   = a_reg[2];
    data_port_odd.strb   = s_reg[2];
    data_port_odd.wdata  = wd_reg[2];
    data_port_odd.src    = own_reg[2];
  end

  ////////////////////////////////////////////////////////////////////////////
  // Completion, stall and forward outputs, lowest port index wins
  always_ff @(posedge clk) begin
    if (rst) begin
      done_src      <= TCP_SRC_NONE;
      done_rdata    <= 64'h0000_0000_0000_0000;
      done_fault    <= 1'b0;
      done_load_ok  <= 1'b0;
      usage_fault_a <= 1'b0;
      stall_src     <= TCP_SRC_NONE;
      main_bus_master_port_req  <= 1'b0;
      main_bus_master_port_addr <= 32'h0000_0000;
      main_bus_master_port_src  <= TCP_SRC_NONE;
    end else begin
      done_src      <= TCP_SRC_NONE;
      done_fault    <= 1'b0;
      done_load_ok  <= 1'b0;
      usage_fault_a <= 1'b0;
      for (int p = 2; p >= 0; p--) begin
        if (st_reg[p] == TCP_ST_RESP && (fin[p] || (!req_reg[p] && wr_reg[p] && flt_reg[p]))) begin
          done_src   <= own_reg[p];
          done_rdata <= rd_w[p];
          // Memory error faults unless speculative
          done_fault <= flt_reg[p] || (er_w[p] && !spec_reg[p]);
          // Faulting read data not loaded
          done_load_ok  <= !wr_reg[p] && !flt_reg[p] && !(er_w[p] && !spec_reg[p]);
          usage_fault_a <= own_reg[p] == TCP_SRC_LSU && flt_reg[p] && lsu_algn;
        end
      end
      // Lower requester blocked by a higher one requesting the same port
      if (sys_req && |(sys_hit & ((lsu_req ? lsu_hit : 3'h0) | (pfu_req ? pfu_hit : 3'h0)))) begin
        stall_src <= TCP_SRC_SLAVE;
      end else if (pfu_req && |(pfu_hit & (lsu_req ? lsu_hit : 3'h0))) begin
        stall_src <= TCP_SRC_FETCH;
      end else begin
        stall_src <= TCP_SRC_NONE;
      end
      // Load/store or prefetch miss on all local ports goes to main bus
      main_bus_master_port_req <= (lsu_req && lsu_hit == 3'h0) || (pfu_req && pfu_hit == 3'h0);
      main_bus_master_port_addr <= (lsu_req && lsu_hit == 3'h0) ? lsu_addr : pfu_addr;
      main_bus_master_port_src  <= (lsu_req && lsu_hit == 3'h0) ? TCP_SRC_LSU : TCP_SRC_FETCH;
    end
  end
endmodule : tcp_core_ports

//--- logic/tcp_link_if.sv
// Purpose: One local memory port between core side and memory controller.
// Assumes: Both ends on clk; controller answers next non-waited cycle.
// Notes:   DW chooses 64-bit instruction or 32-bit data width.
interface tcp_link_if #(parameter int DW = 32) (input wire logic clk);
  logic                 req;
  logic                 wr;
  logic [31:0]          addr;
  logic [DW/8-1:0]      strb;
  logic [DW-1:0]        wdata;
  tcp_pkg::tcp_src_t    src;
  logic [DW-1:0]        rdata;
  logic                 wait_st;
  logic                 err;
  logic                 retry;

  modport core (output req, wr, addr, strb, wdata, src,
                input  rdata, wait_st, err, retry);
  modport mem  (input  req, wr, addr, strb, wdata, src,
                output rdata, wait_st, err, retry);
endinterface : tcp_link_if

//--- logic/tcp_mem_ctrl.sv
// Purpose: Memory controller end of one local port with attached SRAM.
// Assumes: Requests are single-cycle pulses; depth fixed by parameter.
// Notes:   Reads and writes are idempotent, so repeats are harmless.
module tcp_mem_ctrl #(
  parameter int DW     = 32,
  parameter int LOG2_W = 10
) (
  // Clock and reset
  input  wire logic  clk,
  input  wire logic  rst,
  // Link
  tcp_link_if.mem    link,
  // Memory controller controls
  input  wire logic  stall_in,
  input  wire logic  err_in,
  input  wire logic  retry_in
);
  import tcp_pkg::*;

  localparam int BW = DW / 8;
  localparam int AL = $clog2(BW);

  logic [DW-1:0]     mem_q [2**LOG2_W];
  logic              busy_reg;
  logic [LOG2_W-1:0] idx_reg;
  logic [LOG2_W-1:0] idx_w;

  assign idx_w = link.addr[AL +: LOG2_W];

  ////////////////////////////////////////////////////////////////////////////
  // Writes apply bytes; repeated writes leave the same result
  always_ff @(posedge clk) begin
    if (link.req && link.wr) begin
      for (int b = 0; b < BW; b++) begin
        if (link.strb[b]) begin
          mem_q[idx_w][8*b +: 8] <= link.wdata[8*b +: 8];
        end
      end
    end
  end

  // Response pending tracking, wait holds it open
  always_ff @(posedge clk) begin
    if (rst) begin
      busy_reg <= 1'b0;
      idx_reg  <= '0;
    end else if (link.req) begin
      busy_reg <= 1'b1;
      idx_reg  <= idx_w;
    end else if (!stall_in) begin
      busy_reg <= 1'b0;
    end
  end

  // Wait, error and retry only while a response is pending; read data always driven
  always_comb begin
    link.wait_st = busy_reg && stall_in;
    link.err     = busy_reg && !stall_in && err_in;
    link.retry   = busy_reg && !stall_in && retry_in;
    link.rdata   = mem_q[idx_reg];
  end
endmodule : tcp_mem_ctrl

//--- logic/tcp_pkg.sv
// Purpose: Shared constants and types for the local memory ports.
// Assumes: One clock, synchronous active-high reset.
// Notes:   Sizes are log2 of bytes; zero size marks an absent port.
package tcp_pkg;
  localparam int          TCP_IADDR_W     = 32;
  localparam int          TCP_IDATA_W     = 64;
  localparam int          TCP_DDATA_W     = 32;
  localparam int          TCP_ISTRB_W     = 8;
  localparam int          TCP_DSTRB_W     = 4;
  localparam int          TCP_BANK_BIT    = 2;
  localparam int          TCP_ILOG2_SIZE  = 16;
  localparam int          TCP_DLOG2_SIZE  = 17;
  localparam int          TCP_LOG2_MIN    = 12;
  localparam int          TCP_LOG2_MAX    = 24;
  localparam logic [31:0] TCP_IBASE       = 32'h0000_0000;
  localparam logic [31:0] TCP_DBASE       = 32'h2000_0000;
  localparam logic        TCP_RST_BIT     = 1'b0;

  // Requester of an access
  typedef enum logic [1:0] {
    TCP_SRC_NONE  = 2'b00,
    TCP_SRC_FETCH = 2'b01,
    TCP_SRC_LSU   = 2'b10,
    TCP_SRC_SLAVE = 2'b11
  } tcp_src_t;

  // Port state
  typedef enum logic [1:0] {
    TCP_ST_IDLE = 2'b00,
    TCP_ST_RESP = 2'b01,
    TCP_ST_DONE = 2'b10
  } tcp_state_t;
endpackage : tcp_pkg

//--- tb/tcp_link_props.sv
// Purpose: Assertions on the even data port link.
// Assumes: One clock, synchronous active-high reset.
// Notes:   Sees link wires only, not the requesters.
module tcp_link_props #(
  parameter int          DLOG2 = tcp_pkg::TCP_DLOG2_SIZE,
  parameter logic [31:0] DBASE = tcp_pkg::TCP_DBASE
) (
  // Clock and reset
  input wire logic              clk,
  input wire logic              rst,
  // Link signals
  input wire logic              req,
  input wire logic              wr,
  input wire logic [31:0]       addr,
  input wire tcp_pkg::tcp_src_t src,
  input wire logic              wait_st,
  input wire logic              retry
);
  import tcp_pkg::*;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);

  ////////////////////////////////////////////////////////////////////////////////
  // Request followed by a waited or a clean answer
  sequence s_waited;
    req ##1 wait_st;
  endsequence
  sequence s_clean;
    req ##1 (!wait_st && !retry);
  endsequence

  ////////////////////////////////////////////////////////////////////////////////
  // Link protocol checks
  a_req_single: assert property (req |=> !req)
    else $error("request longer than one cycle");
  a_src_tagged: assert property (req |-> src != TCP_SRC_NONE)
    else $error("request without source");
  a_even_bank: assert property (req |-> !addr[2])
    else $error("odd word on even port");
  a_fetch_reads: assert property (req && src == TCP_SRC_FETCH |-> !wr)
    else $error("fetch wrote");
  a_addr_window: assert property (req |-> (addr - DBASE) < (32'h1 << DLOG2))
    else $error("address outside local region");
  a_wait_quiet: assert property (s_waited |=> !req)
    else $error("new request during wait");
  a_no_reissue: assert property (s_clean |=> !req)
    else $error("reissue without retry");
  a_reset_quiet: assert property ($fell(rst) |-> !req)
    else $error("request right after reset");
endmodule : tcp_link_props

//--- tb/test_tightly_coupled_memory_ports.sv
// Purpose: Self-checking bench for the core ports and three memory ends.
// Assumes: One knob set drives all three memory controllers.
// Notes:   Inputs change on the falling clock edge only.
module test_tightly_coupled_memory_ports;
  import tcp_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;

  // Data base and first addresses past each local region
  localparam logic [31:0] dbase  = TCP_DBASE;
  localparam logic [31:0] past_d = TCP_DBASE + (32'h1 << TCP_DLOG2_SIZE);
  localparam logic [31:0] past_i = TCP_IBASE + (32'h1 << TCP_ILOG2_SIZE);

  logic        clk, rst, ire, dre, stall, err_k, rty, mreq, dflt, dok, uf;
  logic        lreq, lwr, lspec, lmf, ldev, preq, pspec, pmf, sreq, swr;
  logic        r_f, r_ok, r_u, r_m, st;
  logic [3:0]  lstrb, sstrb;
  logic [31:0] laddr, lwd, paddr, saddr, swd, maddr, r_ma;
  logic [63:0] drd, r_d;
  tcp_src_t    dsrc, ssrc, msrc, r_ms;
  tcp_src_t    ord [3];
  int          errors = 0;
  int          compares = 0;
  int          n_e = 0, n_o = 0, n_i = 0, r_c, i, k, n0, n1;

  // Clock generation
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Links, core end, memory ends and link checker
  tcp_link_if #(.DW(64)) l_i (.clk(clk));
  tcp_link_if #(.DW(32)) l_e (.clk(clk));
  tcp_link_if #(.DW(32)) l_o (.clk(clk));
  tcp_core_ports i_tcp_core_ports (
    .clk(clk), .rst(rst), .instr_retry_enable(ire), .data_retry_enable(dre),
    .lsu_req(lreq), .lsu_wr(lwr), .lsu_addr(laddr), .lsu_strb(lstrb), .lsu_wdata(lwd),
    .lsu_spec(lspec), .lsu_mpu_fault(lmf), .lsu_dev_type(ldev),
    .pfu_req(preq), .pfu_addr(paddr), .pfu_spec(pspec), .pfu_mpu_fault(pmf),
    .sys_req(sreq), .sys_wr(swr), .sys_addr(saddr), .sys_strb(sstrb), .sys_wdata(swd),
    .done_src(dsrc), .done_rdata(drd), .done_fault(dflt), .done_load_ok(dok),
    .usage_fault_a(uf), .stall_src(ssrc), .main_bus_master_port_req(mreq),
    .main_bus_master_port_addr(maddr), .main_bus_master_port_src(msrc),
    .instruction_local_ram(l_i), .data_port_even(l_e), .data_port_odd(l_o));
  tcp_mem_ctrl #(.DW(64)) i_tcp_mem_ctrl_i (.clk(clk), .rst(rst), .link(l_i),
    .stall_in(stall), .err_in(err_k), .retry_in(rty));
  tcp_mem_ctrl #(.DW(32)) i_tcp_mem_ctrl_e (.clk(clk), .rst(rst), .link(l_e),
    .stall_in(stall), .err_in(err_k), .retry_in(rty));
  tcp_mem_ctrl #(.DW(32)) i_tcp_mem_ctrl_o (.clk(clk), .rst(rst), .link(l_o),
    .stall_in(stall), .err_in(err_k), .retry_in(rty));
  tcp_link_props #(.DLOG2(TCP_DLOG2_SIZE), .DBASE(TCP_DBASE)) i_tcp_link_props (
    .clk(clk), .rst(rst), .req(l_e.req), .wr(l_e.wr), .addr(l_e.addr),
    .src(l_e.src), .wait_st(l_e.wait_st), .retry(l_e.retry));

  // Count requests seen on each local port
  always @(posedge clk) begin
    if (l_e.req === 1'b1) n_e <= n_e + 1;
    if (l_o.req === 1'b1) n_o <= n_o + 1;
    if (l_i.req === 1'b1) n_i <= n_i + 1;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Compare a data value
  task automatic chk_v(input string nm, input logic [63:0] e, input logic [63:0] g);
    compares++;
    if (g !== e) begin
      errors++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask : chk_v

  // Compare a flag
  task automatic chk_b(input string nm, input logic e, input logic g);
    compares++;
    if (g !== e) begin
      errors++;
      $display("BAD %s expected %b seen %b", nm, e, g);
    end
  endtask : chk_b

  // One access held until done or forwarded; flags f are spec, mpu fault, device
  task automatic acc(input tcp_src_t who, input logic w, input logic [31:0] a,
                     input logic [31:0] d, input logic [3:0] s, input logic [2:0] f);
    int j;
    @(negedge clk);
    case (who)
      TCP_SRC_LSU:   {lreq, lwr, laddr, lwd, lstrb, lspec, lmf, ldev} = {1'b1, w, a, d, s, f};
      TCP_SRC_FETCH: {preq, paddr, pspec, pmf} = {1'b1, a, f[2:1]};
      default:       {sreq, swr, saddr, swd, sstrb} = {1'b1, w, a, d, s};
    endcase
    r_u = 1'b0;
    r_m = 1'b0;
    for (j = 0; j < 40 && !r_m && dsrc !== who; j++) begin
      @(posedge clk);
      #1;
      r_u = r_u | (uf === 1'b1);
      r_m = (mreq === 1'b1);
    end
    {r_c, r_d, r_f, r_ok, r_ma, r_ms} = {j, drd, dflt, dok, maddr, msrc};
    @(negedge clk);
    {lreq, preq, sreq} = 3'h0;
    chk_b("completion", 1'b1, j < 40);
  endtask : acc

  // Load/store word write and checked read
  task automatic lw(input logic [31:0] a, input logic [31:0] d);
    acc(TCP_SRC_LSU, 1'b1, a, d, 4'hF, 3'h0);
  endtask : lw
  task automatic lr(input logic [31:0] a, input logic [31:0] e);
    acc(TCP_SRC_LSU, 1'b0, a, 32'h0, 4'hF, 3'h0);
    chk_v("read data", {32'h0, e}, {32'h0, r_d[31:0]});
  endtask : lr

  // Verdict and end of run
  task automatic print_verdict();
    $display("Comparisons %0d, errors %0d", compares, errors);
    if (errors == 0 && compares > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : print_verdict

  // Hang guard well past the expected run
  initial begin
    #200000;
    errors++;
    print_verdict();
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    {rst, ire, dre, stall, err_k, rty} = 6'h20;
    {lreq, lwr, lspec, lmf, ldev, preq, pspec, pmf, sreq, swr} = 10'h000;
    {laddr, lwd, paddr, saddr, swd, lstrb, sstrb} = '0;
    repeat (6) @(negedge clk);
    rst = 1'b0;
    chk_b("idle done", 1'b1, dsrc === TCP_SRC_NONE);
    lw(dbase + 32'h10, 32'hA5A5_0001);
    lw(dbase + 32'h14, 32'h5A5A_0002);
    lw(dbase + 32'h20, 32'h1111_2222);
    lr(dbase + 32'h10, 32'hA5A5_0001);
    chk_b("read latency", 1'b1, r_c == 3);
    chk_b("load ok", 1'b1, r_ok);
    lr(dbase + 32'h14, 32'h5A5A_0002);
    chk_b("bank split", 1'b1, n_e == 3 && n_o == 2 && n_i == 0);
    lw(TCP_IBASE + 32'h100, 32'hC0DE_0001);
    lw(TCP_IBASE + 32'h104, 32'hC0DE_0002);
    acc(TCP_SRC_FETCH, 1'b0, TCP_IBASE + 32'h100, 32'h0, 4'hF, 3'h0);
    chk_v("fetch data", 64'hC0DE_0002_C0DE_0001, r_d);
    chk_b("instr port use", 1'b1, n_i == 3);
    stall = 1'b1;
    fork
      lr(dbase + 32'h14, 32'h5A5A_0002);
      begin
        repeat (5) @(negedge clk);
        stall = 1'b0;
      end
    join
    chk_b("wait stretch", 1'b1, r_c > 4);
    err_k = 1'b1;
    acc(TCP_SRC_LSU, 1'b0, dbase + 32'h10, 32'h0, 4'hF, 3'h0);
    chk_b("error fault", 1'b1, r_f && !r_ok);
    acc(TCP_SRC_LSU, 1'b0, dbase + 32'h10, 32'h0, 4'hF, 3'h4);
    chk_b("spec error", 1'b0, r_f);
    acc(TCP_SRC_FETCH, 1'b0, TCP_IBASE + 32'h100, 32'h0, 4'hF, 3'h4);
    chk_b("fetch spec error", 1'b0, r_f);
    err_k = 1'b0;
    rty = 1'b1;
    n0 = n_e;
    lr(dbase + 32'h10, 32'hA5A5_0001);
    chk_b("retry off", 1'b1, n_e == n0 + 1);
    {dre, ire} = 2'h3;
    n1 = n_i;
    acc(TCP_SRC_FETCH, 1'b0, TCP_IBASE + 32'h100, 32'h0, 4'hF, 3'h4);
    chk_b("fetch retry spec", 1'b1, n_i == n1 + 1);
    acc(TCP_SRC_LSU, 1'b0, dbase + 32'h10, 32'h0, 4'hF, 3'h4);
    chk_b("retry spec", 1'b1, n_e == n0 + 2);
    fork
      lr(dbase + 32'h10, 32'hA5A5_0001);
      begin
        @(posedge clk iff l_e.req === 1'b1);
        @(posedge clk);
        @(negedge clk);
        rty = 1'b0;
      end
    join
    chk_b("retry reissue", 1'b1, n_e == n0 + 4);
    acc(TCP_SRC_LSU, 1'b1, dbase + 32'h20, 32'hDEAD_BEEF, 4'h6, 3'h1);
    chk_b("align write", 1'b1, r_u && r_f && n_e == n0 + 4);
    acc(TCP_SRC_LSU, 1'b1, dbase + 32'h20, 32'hDEAD_BEEF, 4'hF, 3'h2);
    chk_b("mpu write", 1'b1, r_f && n_e == n0 + 4);
    acc(TCP_SRC_FETCH, 1'b0, TCP_IBASE + 32'h100, 32'h0, 4'hF, 3'h2);
    chk_b("fetch mpu fault", 1'b1, r_f && !r_ok);
    acc(TCP_SRC_LSU, 1'b0, dbase + 32'h20, 32'h0, 4'h6, 3'h1);
    chk_b("align read", 1'b1, r_u && !r_ok);
    acc(TCP_SRC_LSU, 1'b0, dbase + 32'h20, 32'h0, 4'hF, 3'h1);
    chk_v("kept word", 64'h1111_2222, {32'h0, r_d[31:0]});
    chk_b("aligned device", 1'b0, r_u);
    acc(TCP_SRC_SLAVE, 1'b1, dbase + 32'h2C, 32'h0BAD_F00D, 4'hF, 3'h0);
    acc(TCP_SRC_SLAVE, 1'b0, dbase + 32'h2C, 32'h0, 4'hF, 3'h0);
    chk_v("slave read", 64'h0BAD_F00D, {32'h0, r_d[31:0]});
    acc(TCP_SRC_LSU, 1'b0, past_d, 32'h0, 4'hF, 3'h0);
    chk_v("main lsu", {29'h0, 1'b1, TCP_SRC_LSU, past_d}, {29'h0, r_m, r_ms, r_ma});
    acc(TCP_SRC_FETCH, 1'b0, past_i, 32'h0, 4'hF, 3'h0);
    chk_v("main fetch", {29'h0, 1'b1, TCP_SRC_FETCH, past_i}, {29'h0, r_m, r_ms, r_ma});
    // Three requesters race for the even port
    {laddr, paddr, saddr, swr, k, st} = {dbase + 32'h10, dbase + 32'h10, dbase + 32'h10, 34'h0};
    {lreq, preq, sreq} = 3'h7;
    for (i = 0; i < 60 && k < 3; i++) begin
      @(posedge clk);
      #1;
      st = st | (ssrc !== TCP_SRC_NONE);
      if (dsrc !== TCP_SRC_NONE) begin
        ord[k] = dsrc;
        k++;
        @(negedge clk);
        lreq = lreq & (ord[k-1] !== TCP_SRC_LSU);
        preq = preq & (ord[k-1] !== TCP_SRC_FETCH);
        sreq = sreq & (ord[k-1] !== TCP_SRC_SLAVE);
      end
    end
    chk_v("priority order", 64'h27, {58'h0, ord[0], ord[1], ord[2]});
    chk_b("lower stalled", 1'b1, st);
    print_verdict();
  end
endmodule : test_tightly_coupled_memory_ports
